// file: logic/rcos_defines.vh
// Register map and field constants for the recovered clock output select block
`ifndef RCOS_DEFINES_VH
`define RCOS_DEFINES_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define RCOS_IDX_ONE        8'h17
`define RCOS_IDX_TWO        8'h18
`define RCOS_ADDR_ONE       {`RCOS_IDX_ONE, 2'h0}
`define RCOS_ADDR_TWO       {`RCOS_IDX_TWO, 2'h0}
`define RCOS_ADDR_W         10

// ****************************************************************
// Control register fields
// ****************************************************************
`define RCOS_EN_BIT         15
`define RCOS_SRC_HI         14
`define RCOS_SRC_LO         11
`define RCOS_FRQ_HI         10
`define RCOS_FRQ_LO         8
`define RCOS_SQL_HI         5
`define RCOS_SQL_LO         4
`define RCOS_TYP_HI         2
`define RCOS_TYP_LO         0
`define RCOS_CTRL_RST       16'h0000
// Writable bits; 7:6 and 3 stay reserved
`define RCOS_CTRL_WMASK     16'hFF37

// ****************************************************************
// Codes
// ****************************************************************
`define RCOS_SRC_PORT0      4'h0
`define RCOS_SRC_PORT1      4'h1
`define RCOS_FRQ_25         3'h0
`define RCOS_FRQ_125        3'h1
`define RCOS_FRQ_31         3'h2
`define RCOS_SQL_STRICT     2'h0
`define RCOS_SQL_RELAXED    2'h1
`define RCOS_SQL_LINKDOWN   2'h2
`define RCOS_SQL_NEVER      2'h3
`define RCOS_TYP_SERIAL     3'h0
`define RCOS_TYP_COPPER     3'h1
`define RCOS_TYP_TX         3'h2

// ****************************************************************
// Divider terminal counts, in base ticks per toggle minus one
// ****************************************************************
`define RCOS_DIV_125        3'h0
`define RCOS_DIV_25         3'h4
`define RCOS_DIV_31         3'h3

// ****************************************************************
// Link state encoding per port
// ****************************************************************
`define RCOS_LNK_DOWN       3'h0
`define RCOS_LNK_UNSTABLE   3'h1
`define RCOS_LNK_NORMAL     3'h2
`define RCOS_LNK_NOREC      3'h3
`define RCOS_LNK_EEE        3'h4
`define RCOS_LNK_EEE_LPI    3'h5

// ****************************************************************
// AXI responses
// ****************************************************************
`define RCOS_RESP_OKAY      2'h0
`define RCOS_RESP_SLVERR    2'h2

`endif

// file: logic/rcos_out_path.v
// One recovered clock output path: source, type and rate select with squelch
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.vh"

module rcos_out_path #(
    parameter TX_ALLOWED = 1
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Control fields
    input  wire [15:0] ctrl_i,
    input  wire        squelch_pin_i,
    // Per-port clock enables, index = port
    input  wire [1:0]  serial_ce_i,
    input  wire [1:0]  copper_ce_i,
    input  wire [1:0]  txclk_ce_i,
    // Per-port link state
    input  wire [2:0]  link0_i,
    input  wire [2:0]  link1_i,
    // Output
    output reg         clk_out_o,
    output wire        active_o
);
    wire [3:0] src = ctrl_i[`RCOS_SRC_HI:`RCOS_SRC_LO];
    wire [2:0] frq = ctrl_i[`RCOS_FRQ_HI:`RCOS_FRQ_LO];
    wire [1:0] sql = ctrl_i[`RCOS_SQL_HI:`RCOS_SQL_LO];
    wire [2:0] typ = ctrl_i[`RCOS_TYP_HI:`RCOS_TYP_LO];

    // (R3) source port select
    wire       src_ok = (src == `RCOS_SRC_PORT0) || (src == `RCOS_SRC_PORT1);
    wire       port   = (src == `RCOS_SRC_PORT1);
    wire [2:0] link   = port ? link1_i : link0_i;

    // (R10) (R11) clock type; transmit clock only where allowed
    reg typ_ok;
    reg base_ce;
    always @* begin
        typ_ok  = 1'b1;
        base_ce = 1'b0;
        case (typ)
            `RCOS_TYP_SERIAL: base_ce = serial_ce_i[port];
            `RCOS_TYP_COPPER: base_ce = copper_ce_i[port];
            `RCOS_TYP_TX: begin
                typ_ok  = (TX_ALLOWED != 0);
                base_ce = txclk_ce_i[port];
            end
            default: typ_ok = 1'b0;
        endcase
    end

    // (R5) (R6) (R7) (R8) squelch policy by link state
    reg link_ok;
    always @* begin
        case (sql)
            `RCOS_SQL_STRICT:   link_ok = (link == `RCOS_LNK_NORMAL);
            `RCOS_SQL_RELAXED:  link_ok = (link == `RCOS_LNK_NORMAL) ||
                                          (link == `RCOS_LNK_NOREC) ||
                                          (link == `RCOS_LNK_EEE_LPI);
            `RCOS_SQL_LINKDOWN: link_ok = (link != `RCOS_LNK_DOWN);
            default:            link_ok = 1'b1;
        endcase
    end

    // (R4) frequency code; reserved codes give no toggle
    wire frq_ok = (frq == `RCOS_FRQ_25) || (frq == `RCOS_FRQ_125) ||
                  (frq == `RCOS_FRQ_31);
    // Divide base edge rate: 125 passes, 25 by 5, 31.25 by 4
    reg  [2:0] div_reg;
    wire [2:0] div_last = (frq == `RCOS_FRQ_25) ? `RCOS_DIV_25 :
                          (frq == `RCOS_FRQ_31) ? `RCOS_DIV_31 : `RCOS_DIV_125;
    wire       div_hit  = (div_reg >= div_last);

    // (R1) (R2) (R9) (R13) enable, pin override, reserved codes
    assign active_o = ctrl_i[`RCOS_EN_BIT] && !squelch_pin_i && src_ok &&
                      typ_ok && frq_ok && link_ok;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg   <= 3'h0;
            clk_out_o <= 1'b0;
        end else if (!active_o) begin
            div_reg   <= 3'h0;
            clk_out_o <= 1'b0;
        end else if (base_ce) begin
            if (div_hit) begin
                div_reg   <= 3'h0;
                clk_out_o <= ~clk_out_o;
            end else begin
                div_reg <= div_reg + 3'h1;
            end
        end
    end
endmodule

`default_nettype wire

// file: logic/rcos_sync.v
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module rcos_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_b_i,
    // Data
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule

`default_nettype wire

// file: logic/rcos_top.v
// Recovered clock output select: AXI4-Lite control and two output paths
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.vh"

// Notes on behaviour
// (R1) Output one toggles only while its enable bit is one.
// (R2) Output two toggles only while bit 15 is set; resets to zero.
// (R3) Source field 0000 picks port zero, 0001 port one.
// (R4) Frequency codes 000/001/010 give 25, 125, 31.25 MHz respectively.
// (R5) Squelch 00: low unless link up in a normal recovering mode.
// (R6) Squelch 01: also runs in master, 10BASE-T and LP_IDLE.
// (R7) Squelch 10: low only while the link is down.
// (R8) Squelch 11: never squelched, clock runs even with link down.
// (R9) High squelch pin forces both outputs low regardless of registers.
// (R10) Output one types: serial, copper recovered, copper transmit clock.
// (R11) Output two types: serial or copper recovered only.
// (R12) Bits 7:6 and 3 are reserved, read-only zero.
// (R13) Reserved source, frequency or type codes hold the output low.
module rcos_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // AXI4-Lite write address
    input  wire [31:0] s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // AXI4-Lite read address
    input  wire [31:0] s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Per-port clock-rate enables, 125 MHz-equivalent edge ticks
    input  wire [1:0]  serial_ce_i,
    input  wire [1:0]  copper_ce_i,
    input  wire [1:0]  copper_transmit_clock_ce_i,
    // Per-port link state
    input  wire [2:0]  link_state0_i,
    input  wire [2:0]  link_state1_i,
    // External squelch pin
    input  wire        clk_squelch_pin_i,
    // Recovered clock outputs
    output wire        recovered_clock_out_one_o,
    output wire        recovered_clock_out_two_o,
    output wire [1:0]  out_active_o
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [15:0] ctrl_one_reg;
    reg  [15:0] ctrl_two_reg;
    wire        squelch_sync;

    // Pin is asynchronous to clk_i
    rcos_sync #(
        .W (1)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (clk_squelch_pin_i),
        .q_o     (squelch_sync)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function [1:0] reg_sel;
        input [31:0] addr;
        begin
            if (addr[`RCOS_ADDR_W-1:0] == `RCOS_ADDR_ONE && addr[31:`RCOS_ADDR_W] == 22'h0)
                reg_sel = 2'h1;
            else if (addr[`RCOS_ADDR_W-1:0] == `RCOS_ADDR_TWO &&
                     addr[31:`RCOS_ADDR_W] == 22'h0)
                reg_sel = 2'h2;
            else
                reg_sel = 2'h0;
        end
    endfunction

    // (R12) reserved bits never stored
    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        reg   [15:0] m;
        begin
            m     = {{8{strb[1]}}, {8{strb[0]}}} & `RCOS_CTRL_WMASK;
            merge = (old & ~m) | (data[15:0] & m);
        end
    endfunction

    // ****************************************************************
    // Write channel
    // ****************************************************************
    reg         aw_held_reg;
    reg [31:0]  aw_addr_reg;
    reg         w_held_reg;
    reg [31:0]  w_data_reg;
    reg [3:0]   w_strb_reg;

    assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;

    wire        aw_fire = s_axi_awvalid_i && s_axi_awready_o;
    wire        w_fire  = s_axi_wvalid_i && s_axi_wready_o;
    wire        aw_have = aw_held_reg || aw_fire;
    wire        w_have  = w_held_reg || w_fire;
    wire [31:0] wa      = aw_held_reg ? aw_addr_reg : s_axi_awaddr_i;
    wire [31:0] wd      = w_held_reg ? w_data_reg : s_axi_wdata_i;
    wire [3:0]  ws      = w_held_reg ? w_strb_reg : s_axi_wstrb_i;
    wire        do_wr   = aw_have && w_have && !s_axi_bvalid_o;
    wire [1:0]  wsel    = reg_sel(wa);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_held_reg    <= 1'b0;
            aw_addr_reg    <= 32'h0;
            w_held_reg     <= 1'b0;
            w_data_reg     <= 32'h0;
            w_strb_reg     <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `RCOS_RESP_OKAY;
            ctrl_one_reg   <= `RCOS_CTRL_RST;
            ctrl_two_reg   <= `RCOS_CTRL_RST;
        end else begin
            if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
            if (do_wr) begin
                aw_held_reg    <= 1'b0;
                w_held_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (wsel == 2'h0) ? `RCOS_RESP_SLVERR : `RCOS_RESP_OKAY;
                // (R1) (R2) enable and fields steer the paths
                if (wsel == 2'h1)
                    ctrl_one_reg <= merge(ctrl_one_reg, wd, ws);
                if (wsel == 2'h2)
                    ctrl_two_reg <= merge(ctrl_two_reg, wd, ws);
            end else begin
                if (aw_fire) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr_i;
                end
                if (w_fire) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata_i;
                    w_strb_reg <= s_axi_wstrb_i;
                end
            end
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign s_axi_arready_o = !s_axi_rvalid_o;
    wire [1:0] rsel = reg_sel(s_axi_araddr_i);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0;
            s_axi_rresp_o  <= `RCOS_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= (rsel == 2'h0) ? `RCOS_RESP_SLVERR : `RCOS_RESP_OKAY;
            case (rsel)
                2'h1:    s_axi_rdata_o <= {16'h0, ctrl_one_reg};
                2'h2:    s_axi_rdata_o <= {16'h0, ctrl_two_reg};
                default: s_axi_rdata_o <= 32'h0;
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Output paths
    // ****************************************************************
    // (R10) transmit clock offered on output one
    rcos_out_path #(
        .TX_ALLOWED (1)
    ) u_path_one (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .ctrl_i        (ctrl_one_reg),
        .squelch_pin_i (squelch_sync),
        .serial_ce_i   (serial_ce_i),
        .copper_ce_i   (copper_ce_i),
        .txclk_ce_i    (copper_transmit_clock_ce_i),
        .link0_i       (link_state0_i),
        .link1_i       (link_state1_i),
        .clk_out_o     (recovered_clock_out_one_o),
        .active_o      (out_active_o[0])
    );

    // (R11) no transmit clock on output two
    rcos_out_path #(
        .TX_ALLOWED (0)
    ) u_path_two (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .ctrl_i        (ctrl_two_reg),
        .squelch_pin_i (squelch_sync),
        .serial_ce_i   (serial_ce_i),
        .copper_ce_i   (copper_ce_i),
        .txclk_ce_i    (copper_transmit_clock_ce_i),
        .link0_i       (link_state0_i),
        .link1_i       (link_state1_i),
        .clk_out_o     (recovered_clock_out_two_o),
        .active_o      (out_active_o[1])
    );
endmodule

`default_nettype wire

// file: tb/rcos_sync_sink.sv
// Far-side synchroniser model that counts recovered clock rising edges
`timescale 1ns/1ps
`default_nettype none
module rcos_sync_sink (
    // Clock and control
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    // Recovered clocks
    input  wire logic        clk_a_i,
    input  wire logic        clk_b_i,
    // Edge counts
    output var  logic [15:0] cnt_a_o,
    output var  logic [15:0] cnt_b_o
);
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    // Outputs only move on system edges, so sampling there sees every toggle
    always @(posedge clk_i) begin
        a_q <= clk_a_i;
        b_q <= clk_b_i;
        cnt_a_o <= clr_i ? 16'h0 : cnt_a_o + {15'h0, clk_a_i & !a_q};
        cnt_b_o <= clr_i ? 16'h0 : cnt_b_o + {15'h0, clk_b_i & !b_q};
    end
endmodule
`default_nettype wire

// file: tb/rcos_top_props.sv
// Port-level assertions for the recovered clock output select block
`timescale 1ns/1ps
`default_nettype none
module rcos_top_props (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    // Register bus
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    // Squelch pin and clock outputs
    input wire logic        clk_squelch_pin_i,
    input wire logic        recovered_clock_out_one_o,
    input wire logic        recovered_clock_out_two_o,
    input wire logic [1:0]  out_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Four samples cover the two sync flops with a cycle of margin
    sequence pin_held;
        clk_squelch_pin_i [*4];
    endsequence
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    off_one_a: assert property (!out_active_o[0] |=> !recovered_clock_out_one_o)
        else $error("output one high while inactive");
    off_two_a: assert property (!out_active_o[1] |=> !recovered_clock_out_two_o)
        else $error("output two high while inactive");
    rise_two_a: assert property ($rose(recovered_clock_out_two_o) |-> $past(out_active_o[1]))
        else $error("output two rose without being active");
    pin_squelch_a: assert property (pin_held |-> out_active_o == 2'h0)
        else $error("outputs active with squelch pin high");
    rsv_bits_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[7:6] == 2'h0 && !s_axi_rdata_o[3])
        else $error("reserved bits read nonzero");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    b_answer_a: assert property (wr_taken |=> s_axi_bvalid_o)
        else $error("no write response one cycle after");
    r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("no read data one cycle after");
endmodule
bind rcos_top rcos_top_props u_props (
    .clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .clk_squelch_pin_i,
    .recovered_clock_out_one_o, .recovered_clock_out_two_o, .out_active_o
);
`default_nettype wire

// file: tb/recovered_clock_output_select_test.sv
// Self-checking bench for the recovered clock output select block
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.vh"
module recovered_clock_output_select_test;
    localparam logic [31:0] A1 = {22'h0, `RCOS_ADDR_ONE};
    localparam logic [31:0] A2 = {22'h0, `RCOS_ADDR_TWO};
    logic        clk_i = 1'b0, rst_b_i = 1'b0, clk_squelch_pin_i = 1'b0, clr = 1'b1;
    logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, sp = 1'b0;
    logic [1:0]  serial_ce_i = 2'h0, copper_ce_i = 2'h0, copper_transmit_clock_ce_i = 2'h0;
    logic [2:0]  link_state0_i = 3'h0, link_state1_i = 3'h0;
    logic [1:0]  st = 2'h0, cyc = 2'h0, tk_all, tk_sel;
    wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    wire         s_axi_rvalid_o, recovered_clock_out_one_o, recovered_clock_out_two_o;
    wire [1:0]   s_axi_bresp_o, s_axi_rresp_o, out_active_o;
    wire [31:0]  s_axi_rdata_o;
    wire [15:0]  cnt_one, cnt_two;
    logic [33:0] q_r[$];
    logic [1:0]  q_b[$];
    logic [15:0] rnd;
    int          failures = 0, n_tests = 0, seed = 7, i;
    rcos_top u_dut (
        .clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .serial_ce_i, .copper_ce_i,
        .copper_transmit_clock_ce_i, .link_state0_i, .link_state1_i, .clk_squelch_pin_i,
        .recovered_clock_out_one_o, .recovered_clock_out_two_o, .out_active_o
    );
    rcos_sync_sink u_sink (
        .clk_i, .clr_i(clr), .clk_a_i(recovered_clock_out_one_o),
        .clk_b_i(recovered_clock_out_two_o), .cnt_a_o(cnt_one), .cnt_b_o(cnt_two)
    );
    always #25 clk_i = ~clk_i;
    // Selected source ticks twice as often as the rest, so a wrong pick halves the count
    assign tk_all = {2{cyc == 2'h0}};
    assign tk_sel = cyc[0] ? 2'h0 : (2'h1 << sp);
    always @(posedge clk_i) begin
        cyc <= cyc + 2'h1;
        serial_ce_i <= tk_all | (st == 2'h0 ? tk_sel : 2'h0);
        copper_ce_i <= tk_all | (st == 2'h1 ? tk_sel : 2'h0);
        copper_transmit_clock_ce_i <= tk_all | (st == 2'h2 ? tk_sel : 2'h0);
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_v(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            check_v("handshake", 34'h1, 34'h0);
            print_verdict();
        end
    endtask
    always @(posedge clk_i) begin
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            check_v("read", q_r.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            check_v("bresp", {32'h0, q_b.pop_front()}, {32'h0, s_axi_bresp_o});
        end
    end
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int   n;
        logic aw_on;
        logic w_on;
        q_b.push_back(r);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        aw_on = 1'b1;
        w_on = 1'b1;
        n = 0;
        // Each channel is released at the edge that takes it
        do begin
            @(posedge clk_i);
            n++;
            if (aw_on && s_axi_awready_o) begin
                s_axi_awvalid_i <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && s_axi_wready_o) begin
                s_axi_wvalid_i <= 1'b0;
                w_on = 1'b0;
            end
        end while ((aw_on || w_on) && n < 50);
        guard(n);
        n = 0;
        do begin @(posedge clk_i); n++; end while (!s_axi_bvalid_o && n < 50);
        s_axi_bready_i <= 1'b0;
        guard(n);
    endtask
    task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        q_r.push_back({r, d});
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (!s_axi_arready_o && n < 50);
        s_axi_arvalid_i <= 1'b0;
        guard(n);
        n = 0;
        do begin @(posedge clk_i); n++; end while (!s_axi_rvalid_o && n < 50);
        s_axi_rready_i <= 1'b0;
        guard(n);
    endtask
    // Program one output, then count rising edges over 80 selected ticks
    task automatic run(input logic sel, input logic [15:0] c, input logic [2:0] a0,
                       input logic [2:0] a1, input logic p, input logic [1:0] ty,
                       input logic pt, input int e);
        logic [15:0] got;
        axi_wr(sel ? A2 : A1, {16'h0, c}, `RCOS_RESP_OKAY);
        link_state0_i <= a0;
        link_state1_i <= a1;
        clk_squelch_pin_i <= p;
        st <= ty;
        sp <= pt;
        repeat (4) @(posedge clk_i);
        clr <= 1'b0;
        repeat (160) @(posedge clk_i);
        clr <= 1'b1;
        got = sel ? cnt_two : cnt_one;
        // Divider phase is unknown at the window start, hence one edge of slack
        n_tests++;
        if ((got <= e + 1 && got + 1 >= e) !== 1'b1) begin
            failures++;
            $display("[ERR] edges of %h expected %0d seen %0d", c, e, got);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        axi_rd(A1, 32'h0, `RCOS_RESP_OKAY);
        axi_rd(A2, 32'h0, `RCOS_RESP_OKAY);
        axi_wr(A1, 32'hFFFFFFFF, `RCOS_RESP_OKAY);
        axi_rd(A1, 32'h0000FF37, `RCOS_RESP_OKAY);
        axi_wr(32'h64, 32'h0000FFFF, `RCOS_RESP_SLVERR);
        axi_rd(32'h64, 32'h0, `RCOS_RESP_SLVERR);
        for (i = 0; i < 4; i++) begin
            rnd = 16'($random(seed));
            axi_wr(A2, {16'h0, rnd}, `RCOS_RESP_OKAY);
            axi_rd(A2, {16'h0, rnd & `RCOS_CTRL_WMASK}, `RCOS_RESP_OKAY);
        end
        run(0, 16'h8100, 2, 0, 0, 0, 0, 40);
        run(0, 16'h0100, 2, 0, 0, 0, 0, 0);
        run(0, 16'h8901, 0, 2, 0, 1, 1, 40);
        run(0, 16'h8002, 2, 0, 0, 2, 0, 8);
        run(0, 16'h8201, 2, 0, 0, 1, 0, 10);
        run(0, 16'h8301, 2, 0, 0, 1, 0, 0);
        run(0, 16'h8103, 2, 0, 0, 1, 0, 0);
        run(0, 16'hA101, 2, 2, 0, 1, 0, 0);
        run(0, 16'h8101, 3, 0, 0, 1, 0, 0);
        run(0, 16'h8101, 4, 0, 0, 1, 0, 0);
        run(0, 16'h8101, 1, 0, 0, 1, 0, 0);
        run(0, 16'h8111, 3, 0, 0, 1, 0, 40);
        run(0, 16'h8111, 5, 0, 0, 1, 0, 40);
        run(0, 16'h8111, 4, 0, 0, 1, 0, 0);
        run(0, 16'h8121, 1, 0, 0, 1, 0, 40);
        run(0, 16'h8121, 0, 0, 0, 1, 0, 0);
        run(0, 16'h8131, 0, 0, 0, 1, 0, 40);
        run(0, 16'h8131, 0, 0, 1, 1, 0, 0);
        run(1, 16'h8101, 2, 0, 0, 1, 0, 40);
        run(1, 16'h8102, 2, 0, 0, 2, 0, 0);
        run(1, 16'h0101, 2, 0, 0, 1, 0, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
